/* File: mlso_cfg.svh */
`ifndef MLSO_CFG_SVH
`define MLSO_CFG_SVH
`define MLSO_A_CTRL   8'h00
`define MLSO_A_WGT    8'h04
`define MLSO_A_ULT    8'h08
`define MLSO_A_PICK   8'h0C
`define MLSO_A_DROP   8'h10
`define MLSO_A_PDLY   8'h14
`define MLSO_A_DDLY   8'h18
`define MLSO_A_HLIM   8'h1C
`define MLSO_A_TLVL   8'h20
`define MLSO_A_STAT   8'h24
`define MLSO_A_MASK   8'h28
`define MLSO_A_LIVE   8'h2C
`define MLSO_A_HEAT   8'h30
`define MLSO_B_SHEDEN 0
`define MLSO_B_CHAN   4:1
`define MLSO_E_SHED   0
`define MLSO_E_REL    1
`define MLSO_E_TRIP   2
`define MLSO_E_FALLB  3
`define MLSO_R_CTRL   5'h00
`define MLSO_R_WGT    8'h60
`define MLSO_R_ULT    16'h0100
`define MLSO_R_PICK   16'h00E0
`define MLSO_R_DROP   16'h00C0
`define MLSO_R_PDLY   16'h000A
`define MLSO_R_DDLY   16'h000A
`define MLSO_R_HLIM   32'h0010_0000
`define MLSO_R_TLVL   8'h64
`define MLSO_WGT_FRAC 4
`define MLSO_COOL_SH  4
`endif

/* File: mlso_pkg.sv */
`default_nettype none
package mlso_pkg;
  typedef enum logic [1:0] {SH_IDLE, SH_PICKUP, SH_SHED, SH_DROPOUT} mlso_shed_t;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [4:0]  ctrl;
    logic [7:0]  wgt;
    logic [15:0] ult;
    logic [15:0] pick;
    logic [15:0] drop;
    logic [15:0] pdly;
    logic [15:0] ddly;
    logic [31:0] hlim;
    logic [7:0]  tlvl;
    logic [3:0]  stat;
    logic [3:0]  mask;
    logic        irq;
    mlso_shed_t  sh;
    logic [15:0] cnt;
    logic        shed;
    logic        trip;
    logic        temp_mode;
    logic        above;
    logic [36:0] ieff;
    logic [39:0] acc;
  } mlso_state_t;
endpackage : mlso_pkg
`default_nettype wire

/* File: mlso_proc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mlso_proc_model (
  input  wire logic        contact,
  input  wire logic [15:0] demand,
  input  wire logic [15:0] relief,
  output logic [15:0]      load
);
  // the process throttles its feed while the shed contact is active
  assign load = contact ? relief : demand;
endmodule : mlso_proc_model
`default_nettype wire

/* File: mlso_top.sv */
// How it works
// - heating squared = pos-seq squared plus weight times neg-seq squared.
// - ultimate trip level, multiple of full load current, bounds heating.
// - above the level heat accumulates while the motor runs; trip only when accumulator hits limit.
// - valid stator temperature below its level withholds heating.
// - lost sensors, module or link fall back to level-only calculation.
// - all temperature channels off means level-only calculation.
// - load shed acts only when enabled, after current exceeds pickup past delay.
// - shed output holds until current drops below the dropout threshold.
// - below dropout, dropout delay must elapse before release.
// - load shed is evaluated only while the motor runs.
`timescale 1ns/1ps
`default_nettype none
`include "mlso_cfg.svh"
module mlso_top
  import mlso_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tick,
  input  wire logic [15:0] i_pos,
  input  wire logic [15:0] i_neg,
  input  wire logic        motor_running,
  input  wire logic        temp_valid,
  input  wire logic        temp_link_ok,
  input  wire logic [7:0]  temp_stator,
  output logic             load_shed_contact,
  output logic             overload_trip,
  output logic             temp_mode,
  output logic             irq
);
  mlso_state_t q;
  mlso_state_t next_q;

  logic [31:0] pos_sq;
  logic [31:0] neg_sq;
  logic [39:0] neg_w;
  logic [36:0] ieff_sq;
  logic [31:0] ult_sq;
  logic        heat_ok;
  logic [39:0] acc_inc;
  logic        wr;
  logic        rd;
  logic [3:0]  ev;
  logic [31:0] rdata;
  logic        hit;

  assign pos_sq  = i_pos * i_pos;
  assign neg_sq  = i_neg * i_neg;
  assign neg_w   = neg_sq * q.wgt;
  // weight carries four fraction bits
  assign ieff_sq = {5'h00, pos_sq} + {1'b0, neg_w[39:`MLSO_WGT_FRAC]};
  assign ult_sq  = q.ult * q.ult;
  // a cold stator soaks up heat, so no accumulation below its level
  assign heat_ok = !q.temp_mode || (temp_stator >= q.tlvl);
  assign acc_inc = {3'h0, q.ieff} - {8'h00, ult_sq};
  assign wr      = psel && penable && q.pready && pwrite;
  assign rd      = psel && penable && q.pready && !pwrite;

  always_comb begin
    hit = 1'b1;
    rdata = 32'h0000_0000;
    unique case (paddr)
      `MLSO_A_CTRL: rdata = {27'h0, q.ctrl};
      `MLSO_A_WGT:  rdata = {24'h0, q.wgt};
      `MLSO_A_ULT:  rdata = {16'h0, q.ult};
      `MLSO_A_PICK: rdata = {16'h0, q.pick};
      `MLSO_A_DROP: rdata = {16'h0, q.drop};
      `MLSO_A_PDLY: rdata = {16'h0, q.pdly};
      `MLSO_A_DDLY: rdata = {16'h0, q.ddly};
      `MLSO_A_HLIM: rdata = q.hlim;
      `MLSO_A_TLVL: rdata = {24'h0, q.tlvl};
      `MLSO_A_STAT: rdata = {28'h0, q.stat};
      `MLSO_A_MASK: rdata = {28'h0, q.mask};
      `MLSO_A_LIVE: rdata = {26'h0, q.sh, q.above, q.temp_mode, q.trip, q.shed};
      `MLSO_A_HEAT: rdata = q.acc[39:8];
      default:      hit = 1'b0;
    endcase
  end

  always_comb begin
    next_q = q;
    ev = 4'h0;
    // no wait state: answer stands in the first access cycle
    next_q.pready = psel && !penable;
    next_q.pslverr = psel && !penable && !hit;
    if (psel && !penable) begin
      next_q.prdata = hit && !pwrite ? rdata : 32'h0000_0000;
    end
    if (wr) begin
      unique case (paddr)
        `MLSO_A_CTRL: next_q.ctrl = pwdata[4:0];
        `MLSO_A_WGT:  next_q.wgt = pwdata[7:0];
        `MLSO_A_ULT:  next_q.ult = pwdata[15:0];
        `MLSO_A_PICK: next_q.pick = pwdata[15:0];
        `MLSO_A_DROP: next_q.drop = pwdata[15:0];
        `MLSO_A_PDLY: next_q.pdly = pwdata[15:0];
        `MLSO_A_DDLY: next_q.ddly = pwdata[15:0];
        `MLSO_A_HLIM: next_q.hlim = pwdata;
        `MLSO_A_TLVL: next_q.tlvl = pwdata[7:0];
        `MLSO_A_MASK: next_q.mask = pwdata[3:0];
        default: ;
      endcase
    end

    next_q.ieff = ieff_sq;
    next_q.above = q.ieff > {5'h00, ult_sq};
    next_q.temp_mode = (q.ctrl[`MLSO_B_CHAN] != 4'h0) && temp_valid && temp_link_ok;
    if (q.temp_mode && !next_q.temp_mode) begin
      ev[`MLSO_E_FALLB] = 1'b1;
    end

    // gradual heating model: no instant trip on crossing the level
    if (tick) begin
      // direct compare: the registered flag lags a falling current, and the
      // increment would then wrap into a false saturation
      if (motor_running && (q.ieff > {5'h00, ult_sq}) && heat_ok) begin
        next_q.acc = (q.acc + acc_inc < q.acc) ? 40'hFF_FFFF_FFFF : q.acc + acc_inc;
      end else begin
        next_q.acc = q.acc - (q.acc >> `MLSO_COOL_SH);
      end
    end
    next_q.trip = next_q.acc[39:8] >= q.hlim;
    if (next_q.trip && !q.trip) begin
      ev[`MLSO_E_TRIP] = 1'b1;
    end

    if (!motor_running || !q.ctrl[`MLSO_B_SHEDEN]) begin
      next_q.sh = SH_IDLE;
      next_q.cnt = 16'h0000;
    end else begin
      unique case (q.sh)
        SH_IDLE: begin
          next_q.cnt = 16'h0000;
          if (i_pos > q.pick) begin
            next_q.sh = SH_PICKUP;
          end
        end
        SH_PICKUP: begin
          if (i_pos <= q.pick) begin
            next_q.sh = SH_IDLE;
            next_q.cnt = 16'h0000;
          end else if (q.cnt >= q.pdly) begin
            next_q.sh = SH_SHED;
            next_q.cnt = 16'h0000;
          end else if (tick) begin
            next_q.cnt = q.cnt + 16'h0001;
          end
        end
        SH_SHED: begin
          next_q.cnt = 16'h0000;
          if (i_pos < q.drop) begin
            next_q.sh = SH_DROPOUT;
          end
        end
        SH_DROPOUT: begin
          if (i_pos >= q.drop) begin
            next_q.sh = SH_SHED;
            next_q.cnt = 16'h0000;
          end else if (q.cnt >= q.ddly) begin
            next_q.sh = SH_IDLE;
            next_q.cnt = 16'h0000;
          end else if (tick) begin
            next_q.cnt = q.cnt + 16'h0001;
          end
        end
      endcase
    end
    next_q.shed = (next_q.sh == SH_SHED) || (next_q.sh == SH_DROPOUT);
    ev[`MLSO_E_SHED] = next_q.shed && !q.shed;
    ev[`MLSO_E_REL] = !next_q.shed && q.shed;

    // a new event in the clearing read cycle survives
    next_q.stat = ((rd && paddr == `MLSO_A_STAT) ? 4'h0 : q.stat) | ev;
    next_q.irq = |(next_q.stat & q.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000,
             ctrl: `MLSO_R_CTRL, wgt: `MLSO_R_WGT, ult: `MLSO_R_ULT,
             pick: `MLSO_R_PICK, drop: `MLSO_R_DROP, pdly: `MLSO_R_PDLY,
             ddly: `MLSO_R_DDLY, hlim: `MLSO_R_HLIM, tlvl: `MLSO_R_TLVL,
             stat: 4'h0, mask: 4'h0, irq: 1'b0, sh: SH_IDLE, cnt: 16'h0000,
             shed: 1'b0, trip: 1'b0, temp_mode: 1'b0, above: 1'b0,
             ieff: 37'h0, acc: 40'h0};
    end else begin
      q <= next_q;
    end
  end

  assign prdata            = q.prdata;
  assign pready            = q.pready;
  assign pslverr           = q.pslverr;
  assign load_shed_contact = q.shed;
  assign overload_trip     = q.trip;
  assign temp_mode         = q.temp_mode;
  assign irq               = q.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_heat_sq;
    $past(presetn) |-> q.ieff == $past(ieff_sq);
  endproperty
  a_heat_sq: assert property (p_heat_sq) else $error("heating current square wrong");

  property p_above;
    $stable(q.ult) && $stable(q.ieff) |-> q.above == (q.ieff > {5'h00, ult_sq});
  endproperty
  a_above: assert property (p_above) else $error("level compare wrong");

  property p_gradual;
    $rose(q.trip) |-> q.acc[39:8] >= q.hlim && $past(q.acc) != q.acc;
  endproperty
  a_gradual: assert property (p_gradual) else $error("trip without heat build-up");

  property p_withhold;
    tick && q.temp_mode && temp_stator < q.tlvl |=> q.acc <= $past(q.acc);
  endproperty
  a_withhold: assert property (p_withhold) else $error("heat grew on cool stator");

  property p_fallback;
    !(temp_valid && temp_link_ok) |=> !q.temp_mode;
  endproperty
  a_fallback: assert property (p_fallback) else $error("no fallback on lost sensors");

  property p_all_off;
    q.ctrl[`MLSO_B_CHAN] == 4'h0 |=> !q.temp_mode;
  endproperty
  a_all_off: assert property (p_all_off) else $error("temperature used with channels off");

  property p_enable;
    !q.ctrl[`MLSO_B_SHEDEN] |=> !load_shed_contact;
  endproperty
  a_enable: assert property (p_enable) else $error("shed while disabled");

  property p_hold;
    q.shed && motor_running && q.ctrl[`MLSO_B_SHEDEN] && i_pos >= q.drop |=> q.shed;
  endproperty
  a_hold: assert property (p_hold) else $error("shed released above dropout");

  property p_release;
    q.shed && !next_q.shed && motor_running && q.ctrl[`MLSO_B_SHEDEN]
      |-> q.sh == SH_DROPOUT && q.cnt >= q.ddly;
  endproperty
  a_release: assert property (p_release) else $error("release before dropout delay");

  property p_not_run;
    !motor_running |=> !q.shed && q.cnt == 16'h0000 && q.sh == SH_IDLE;
  endproperty
  a_not_run: assert property (p_not_run) else $error("shed active out of run");

  property p_pos_sq;
    presetn && i_neg == 16'h0000 |=> q.ieff == 37'($past(i_pos)) * 37'($past(i_pos));
  endproperty
  a_pos_sq: assert property (p_pos_sq) else $error("pos-seq square wrong");

  property p_cool;
    tick && q.ieff <= {5'h00, ult_sq} |=> q.acc <= $past(q.acc);
  endproperty
  a_cool: assert property (p_cool) else $error("heat grew below level");

  property p_heat_up;
    tick && motor_running && !q.temp_mode && q.ieff > {5'h00, ult_sq}
      |=> q.acc >= $past(q.acc);
  endproperty
  a_heat_up: assert property (p_heat_up) else $error("heat fell above level");

  property p_trip_lvl;
    q.trip == (q.acc[39:8] >= $past(q.hlim));
  endproperty
  a_trip_lvl: assert property (p_trip_lvl) else $error("trip not at heat limit");

  property p_pick_dly;
    $rose(q.shed) |-> $past(q.sh == SH_PICKUP && q.cnt >= q.pdly);
  endproperty
  a_pick_dly: assert property (p_pick_dly) else $error("shed before pickup delay");

  property p_shed_stay;
    q.sh == SH_SHED && motor_running && q.ctrl[`MLSO_B_SHEDEN] |=> q.shed;
  endproperty
  a_shed_stay: assert property (p_shed_stay) else $error("shed left shed state");

  property p_drop_wait;
    q.sh == SH_DROPOUT && motor_running && q.ctrl[`MLSO_B_SHEDEN] && q.cnt < q.ddly
      |=> q.shed;
  endproperty
  a_drop_wait: assert property (p_drop_wait) else $error("early dropout release");

  property p_run_only;
    q.sh != SH_IDLE |-> $past(motor_running);
  endproperty
  a_run_only: assert property (p_run_only) else $error("shed busy out of run");
endmodule : mlso_top
`default_nettype wire

/* File: mlso_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module mlso_top_bench;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, tick = 1'b0;
  logic [7:0]  paddr = 8'h00, tstat = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic        pready, pslverr, e, contact, trip, tmode, irq;
  logic        running = 1'b0, tvalid = 1'b0, tlink = 1'b0;
  logic [15:0] i_neg = 16'h0000, demand = 16'h0000, relief = 16'h0000, load;
  int          failures = 0, checks = 0;
  logic [7:0]  ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h28};
  logic [31:0] rv [10] = '{32'h0, 32'h60, 32'h100, 32'hE0, 32'hC0, 32'hA, 32'hA,
                           32'h0010_0000, 32'h64, 32'h0};

  always #25 pclk = ~pclk;

  mlso_top u_mlso_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tick(tick), .i_pos(load), .i_neg(i_neg), .motor_running(running),
    .temp_valid(tvalid), .temp_link_ok(tlink), .temp_stator(tstat),
    .load_shed_contact(contact), .overload_trip(trip), .temp_mode(tmode), .irq(irq));
  mlso_proc_model u_mlso_proc_model (.contact(contact), .demand(demand), .relief(relief),
    .load(load));

  task tally_and_finish;
    if (failures == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  task chk(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, g, x);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) failures++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask : rd

  // settle gaps around each tick cover the two-stage heating pipeline
  task tk(input int n);
    repeat (n) begin
      repeat (3) @(posedge pclk);
      tick <= 1'b1;
      @(posedge pclk);
      tick <= 1'b0;
    end
    repeat (3) @(posedge pclk);
  endtask : tk

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 10; i++) rd(ra[i], rv[i]);
    apb(1'b0, 8'h34, 32'h0);
    chk({31'h0, e}, 32'h1);
    wr(8'h14, 32'h2);
    wr(8'h18, 32'h2);
    wr(8'h08, 32'h100);
    wr(8'h0C, 32'hE0);
    wr(8'h10, 32'hC0);
    demand <= 16'h0100;
    relief <= 16'h00D0;
    running <= 1'b1;
    tk(5);
    chk({31'h0, contact}, 32'h0);
    running <= 1'b0;
    wr(8'h00, 32'h1);
    tk(5);
    chk({31'h0, contact}, 32'h0);
    running <= 1'b1;
    tk(1);
    chk({31'h0, contact}, 32'h0);
    tk(1);
    chk({31'h0, contact}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(8'h28, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    rd(8'h24, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    tk(5);
    chk({31'h0, contact}, 32'h1);
    rd(8'h2C, 32'h21);
    relief <= 16'h0080;
    tk(1);
    chk({31'h0, contact}, 32'h1);
    tk(1);
    chk({31'h0, contact}, 32'h0);
    relief <= 16'h00D0;
    tk(2);
    chk({31'h0, contact}, 32'h1);
    running <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({31'h0, contact}, 32'h0);
    running <= 1'b1;
    tk(1);
    chk({31'h0, contact}, 32'h0);
    wr(8'h00, 32'h0);
    wr(8'h1C, 32'h300);
    i_neg <= 16'h0080;
    tk(1);
    rd(8'h30, 32'h180);
    chk({31'h0, trip}, 32'h0);
    tk(1);
    chk({31'h0, trip}, 32'h1);
    tvalid <= 1'b1;
    tlink <= 1'b1;
    tstat <= 8'h10;
    repeat (3) @(posedge pclk);
    chk({31'h0, tmode}, 32'h0);
    wr(8'h00, 32'h2);
    repeat (2) @(posedge pclk);
    chk({31'h0, tmode}, 32'h1);
    tk(1);
    rd(8'h30, 32'h2D0);
    tlink <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({31'h0, tmode}, 32'h0);
    tk(1);
    rd(8'h30, 32'h450);
    rd(8'h24, 32'hF);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({31'h0, trip}, 32'h0);
    presetn <= 1'b1;
    rd(8'h30, 32'h0);
    rd(8'h24, 32'h0);
    tally_and_finish();
  end

  initial begin
    #100us;
    failures++;
    tally_and_finish();
  end
endmodule : mlso_top_bench
`default_nettype wire
